// >>> core/sfs_pkg.sv
/*
  sfs_pkg: constants and types for the servo fault supervisor.
  assumes a 125 MHz control clock; widths are fixed.
*/
package sfs_pkg;
  localparam int unsigned ERR_W       = 24;
  localparam int unsigned TRK_W       = 16;
  localparam int unsigned TEMP_W      = 12;
  localparam int unsigned VOLT_W      = 12;
  localparam int unsigned FLT_N       = 11;
  localparam int unsigned FLT_W       = 4;
  // fault index positions
  localparam int unsigned F_SHORT     = 0;
  localparam int unsigned F_AMP_TEMP  = 1;
  localparam int unsigned F_MOT_TEMP  = 2;
  localparam int unsigned F_OVER_V    = 3;
  localparam int unsigned F_UNDER_V   = 4;
  localparam int unsigned F_FEEDBACK  = 5;
  localparam int unsigned F_PHASING   = 6;
  localparam int unsigned F_CMD_LOSS  = 7;
  localparam int unsigned F_WIRING    = 8;
  localparam int unsigned F_OVER_CUR  = 9;
  localparam int unsigned F_FOLLOW    = 10;
  // reset value of latch configuration: short, amp temp, motor temp, feedback, over-current and following latch by default
  localparam logic [FLT_N-1:0] LATCH_RST  = 11'h627;
  localparam logic [FLT_W-1:0] CODE_NONE  = 4'hf;
  localparam logic [TRK_W-1:0] TRK_CNT_RST = 16'h0000;

  typedef enum logic [2:0] {
    SFS_FE_RUN  = 3'b001,
    SFS_FE_STOP = 3'b010,
    SFS_FE_OFF  = 3'b100
  } sfs_fe_state_t;
endpackage : sfs_pkg

// >>> core/sfs_supervisor.sv
/*
  sfs_supervisor: fault detection, latch policy, following error handling
  and tracking status for a servo drive.
  assumes condition inputs come from logic on core_clk; pins are synced here.
*/
`timescale 1ns/100ps
`default_nettype none
module sfs_supervisor (
  input  wire logic                              core_clk,
  input  wire logic                              sys_rst,
  input  wire logic                              short_ind,
  input  wire logic [sfs_pkg::TEMP_W-1:0]        amp_temp,
  input  wire logic [sfs_pkg::TEMP_W-1:0]        amp_temp_limit,
  input  wire logic                              motor_thermal_pin,
  input  wire logic                              motor_thermal_hot_level,
  input  wire logic [sfs_pkg::VOLT_W-1:0]        main_bus_supply,
  input  wire logic [sfs_pkg::VOLT_W-1:0]        bus_upper_limit,
  input  wire logic [sfs_pkg::VOLT_W-1:0]        bus_lower_limit,
  input  wire logic [sfs_pkg::VOLT_W-1:0]        auxiliary_supply,
  input  wire logic [sfs_pkg::VOLT_W-1:0]        supply_reset_level,
  input  wire logic                              fb_supply_overcur,
  input  wire logic                              fb_signal_bad,
  input  wire logic                              phase_mismatch,
  input  wire logic                              brushless_sine,
  input  wire logic                              resolver_fb,
  input  wire logic                              hall_correct_en,
  input  wire logic                              cmd_signal_lost,
  input  wire logic                              brake_used,
  input  wire logic                              wiring_check_active,
  input  wire logic                              motor_current_seen,
  input  wire logic                              overcur_fault_en,
  input  wire logic                              heating_limit_hit,
  input  wire logic                              drive_current_reduced,
  input  wire logic [sfs_pkg::FLT_N-1:0]         latch_cfg,
  input  wire logic                              latch_cfg_load,
  input  wire logic                              position_mode,
  input  wire logic                              follow_fault_en,
  input  wire logic [sfs_pkg::ERR_W-1:0]         traj_position,
  input  wire logic [sfs_pkg::ERR_W-1:0]         actual_position,
  input  wire logic [sfs_pkg::ERR_W-1:0]         follow_fault_level,
  input  wire logic [sfs_pkg::ERR_W-1:0]         follow_warn_level,
  input  wire logic [sfs_pkg::ERR_W-1:0]         pos_window,
  input  wire logic [sfs_pkg::TRK_W-1:0]         pos_track_time,
  input  wire logic [sfs_pkg::ERR_W-1:0]         vel_command,
  input  wire logic [sfs_pkg::ERR_W-1:0]         actual_velocity,
  input  wire logic [sfs_pkg::ERR_W-1:0]         vel_window,
  input  wire logic [sfs_pkg::TRK_W-1:0]         vel_track_time,
  input  wire logic                              pin_position_cmd,
  input  wire logic                              new_traj_cmd,
  input  wire logic                              enable_pin,
  input  wire logic                              enable_clears_faults,
  input  wire logic                              sw_enable,
  input  wire logic                              clear_cmd,
  output logic [sfs_pkg::FLT_N-1:0]              fault_flags,
  output logic                                   follow_warn,
  output logic                                   follow_status,
  output logic                                   pos_track_flag,
  output logic                                   vel_track_flag,
  output logic                                   stage_enable,
  output logic                                   brake_release,
  output logic                                   velocity_hold,
  output logic                                   fast_stop,
  output logic                                   fault_indicator,
  output logic                                   fault_out,
  output logic                                   log_valid,
  output logic [sfs_pkg::FLT_W-1:0]              log_code
);
  // pin synchronisers
  logic [1:0] therm_sync_q;
  logic [1:0] en_sync_q;
  logic       en_prev_q;

  // fault state
  logic [sfs_pkg::FLT_N-1:0] cond;
  logic [sfs_pkg::FLT_N-1:0] flags_q;
  logic [sfs_pkg::FLT_N-1:0] flags_d;
  logic [sfs_pkg::FLT_N-1:0] latch_q;
  logic [sfs_pkg::FLT_N-1:0] latch_d;
  logic [sfs_pkg::FLT_N-1:0] cleared_ok;
  logic                      pwr_low_q;
  logic                      pwr_low_d;
  logic                      pwr_clear;
  logic                      clear_ev;
  logic                      en_rise;
  logic                      en_fall;
  logic                      en_now;

  // following error
  logic [sfs_pkg::ERR_W-1:0] pos_err;
  logic [sfs_pkg::ERR_W-1:0] pos_mag;
  logic                      fe_hit;
  logic                      warn_q;
  logic                      warn_d;
  logic                      fe_seen_q;
  logic                      fe_seen_d;
  sfs_pkg::sfs_fe_state_t    fe_q;
  sfs_pkg::sfs_fe_state_t    fe_d;

  // log
  logic                      log_v_q;
  logic                      log_v_d;
  logic [sfs_pkg::FLT_W-1:0] log_c_q;
  logic [sfs_pkg::FLT_W-1:0] log_c_d;
  logic [sfs_pkg::FLT_N-1:0] new_faults;
  logic [sfs_pkg::FLT_N-1:0] pend_q;
  logic [sfs_pkg::FLT_N-1:0] pend_d;

  sfs_track_if pos_trk ();
  sfs_track_if vel_trk ();

  assign pos_trk.err       = pos_err;
  assign pos_trk.window    = pos_window;
  assign pos_trk.hold_time = pos_track_time;
  assign vel_trk.err       = vel_command - actual_velocity;
  assign vel_trk.window    = vel_window;
  assign vel_trk.hold_time = vel_track_time;

  sfs_track u_pos_track (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .trk      (pos_trk)
  );

  sfs_track u_vel_track (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .trk      (vel_trk)
  );

  // condition and clear decode
  always_comb begin
    en_now   = en_sync_q[1];
    en_rise  = en_now & ~en_prev_q;
    en_fall  = ~en_now & en_prev_q;
    pos_err  = traj_position - actual_position;
    pos_mag  = pos_err[sfs_pkg::ERR_W-1] ? (~pos_err + 24'h000001) : pos_err;
    fe_hit   = position_mode & follow_fault_en & (pos_mag >= follow_fault_level);
    cond     = '0;
    cond[sfs_pkg::F_SHORT]    = short_ind;
    cond[sfs_pkg::F_AMP_TEMP] = amp_temp > amp_temp_limit;
    cond[sfs_pkg::F_MOT_TEMP] = therm_sync_q[1] == motor_thermal_hot_level;
    cond[sfs_pkg::F_OVER_V]   = main_bus_supply > bus_upper_limit;
    cond[sfs_pkg::F_UNDER_V]  = main_bus_supply < bus_lower_limit;
    cond[sfs_pkg::F_FEEDBACK] = fb_supply_overcur | fb_signal_bad;
    cond[sfs_pkg::F_PHASING]  = phase_mismatch & brushless_sine & ~resolver_fb
                                & hall_correct_en;
    cond[sfs_pkg::F_CMD_LOSS] = cmd_signal_lost;
    cond[sfs_pkg::F_WIRING]   = brake_used & wiring_check_active & ~motor_current_seen;
    cond[sfs_pkg::F_OVER_CUR] = overcur_fault_en & heating_limit_hit;
    cond[sfs_pkg::F_FOLLOW]   = fe_hit;
    // both supplies below reset level, released on first supply recovery
    pwr_low_d = (main_bus_supply < supply_reset_level)
                & (auxiliary_supply < supply_reset_level);
    pwr_clear = pwr_low_q & ~pwr_low_d;
    clear_ev  = clear_cmd | (enable_clears_faults & en_rise) | pwr_clear;
    cleared_ok = ~cond;
    // over-current stays latched while current has not been reduced
    cleared_ok[sfs_pkg::F_OVER_CUR] = ~cond[sfs_pkg::F_OVER_CUR] & drive_current_reduced;
    // following fault clears through its own state machine
    cleared_ok[sfs_pkg::F_FOLLOW] = 1'b0;
    latch_d = latch_cfg_load ? latch_cfg : latch_q;
    latch_d[sfs_pkg::F_OVER_CUR] = 1'b1;
  end

  // flag policy: set wins over clear
  always_comb begin
    flags_d = flags_q;
    for (int i = 0; i < sfs_pkg::FLT_N; i++) begin
      if (cond[i]) begin
        flags_d[i] = 1'b1;
      end else if (!latch_q[i]) begin
        flags_d[i] = 1'b0;
      end else if (clear_ev && cleared_ok[i]) begin
        flags_d[i] = 1'b0;
      end
    end
    flags_d[sfs_pkg::F_FOLLOW] = (fe_d != sfs_pkg::SFS_FE_RUN);
  end

  // following error state machine
  always_comb begin
    fe_d      = fe_q;
    warn_d    = position_mode & (pos_mag >= follow_warn_level);
    fe_seen_d = fe_seen_q;
    case (fe_q)
      sfs_pkg::SFS_FE_RUN: begin
        if (fe_hit) begin
          fe_d = latch_q[sfs_pkg::F_FOLLOW] ? sfs_pkg::SFS_FE_OFF
                                              : sfs_pkg::SFS_FE_STOP;
        end
      end
      sfs_pkg::SFS_FE_STOP: begin
        if (fe_hit) begin
          fe_d = sfs_pkg::SFS_FE_STOP;
        end else if (pin_position_cmd) begin
          if (en_fall || (!sw_enable)) begin
            fe_seen_d = 1'b1;
          end
          if (fe_seen_q && en_now && sw_enable) begin
            fe_d      = sfs_pkg::SFS_FE_RUN;
            fe_seen_d = 1'b0;
          end
        end else if (new_traj_cmd) begin
          fe_d = sfs_pkg::SFS_FE_RUN;
        end
      end
      sfs_pkg::SFS_FE_OFF: begin
        if (clear_ev && !fe_hit) begin
          fe_d = sfs_pkg::SFS_FE_RUN;
        end
      end
      default: fe_d = sfs_pkg::SFS_FE_RUN;
    endcase
  end

  // error log: one entry per cycle for each newly raised fault
  always_comb begin
    new_faults = flags_d & ~flags_q;
    pend_d     = pend_q | new_faults;
    log_v_d    = 1'b0;
    log_c_d    = log_c_q;
    for (int i = sfs_pkg::FLT_N - 1; i >= 0; i--) begin
      if (pend_d[i]) begin
        log_v_d = 1'b1;
        log_c_d = 4'(i);
      end
    end
    if (log_v_d) begin
      pend_d[log_c_d] = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      therm_sync_q <= {2{~motor_thermal_hot_level}};
      en_sync_q    <= 2'h0;
      en_prev_q    <= 1'b0;
      flags_q      <= '0;
      latch_q      <= sfs_pkg::LATCH_RST;
      pwr_low_q    <= 1'b0;
      warn_q       <= 1'b0;
      fe_seen_q    <= 1'b0;
      fe_q         <= sfs_pkg::SFS_FE_RUN;
      log_v_q      <= 1'b0;
      log_c_q      <= sfs_pkg::CODE_NONE;
      pend_q       <= '0;
    end else begin
      therm_sync_q <= {therm_sync_q[0], motor_thermal_pin};
      en_sync_q    <= {en_sync_q[0], enable_pin};
      en_prev_q    <= en_sync_q[1];
      flags_q      <= flags_d;
      latch_q      <= latch_d;
      pwr_low_q    <= pwr_low_d;
      warn_q       <= warn_d;
      fe_seen_q    <= fe_seen_d;
      fe_q         <= fe_d;
      log_v_q      <= log_v_d;
      log_c_q      <= log_c_d;
      pend_q       <= pend_d;
    end
  end

  // outputs
  logic other_fault;
  always_comb begin
    other_fault     = |(flags_q & ~(11'h001 << sfs_pkg::F_FOLLOW));
    fault_flags     = flags_q;
    follow_warn     = warn_q;
    follow_status   = warn_q | (fe_q != sfs_pkg::SFS_FE_RUN);
    pos_track_flag  = pos_trk.flag;
    vel_track_flag  = vel_trk.flag;
    stage_enable    = ~other_fault & (fe_q != sfs_pkg::SFS_FE_OFF);
    brake_release   = stage_enable;
    velocity_hold   = fe_q == sfs_pkg::SFS_FE_STOP;
    fast_stop       = fe_q == sfs_pkg::SFS_FE_STOP;
    fault_indicator = other_fault | (fe_q == sfs_pkg::SFS_FE_OFF);
    fault_out       = fault_indicator;
    log_valid       = log_v_q;
    log_code        = log_c_q;
  end
endmodule : sfs_supervisor
`default_nettype wire

// >>> core/sfs_track.sv
/*
  sfs_track: windowed tracking status bit for one signed error.
  assumes err, window and hold_time are synchronous to core_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module sfs_track (
  input  wire logic  core_clk,
  input  wire logic  sys_rst,
  sfs_track_if.track trk
);
  logic [sfs_pkg::ERR_W-1:0] mag;
  logic                      outside;
  logic                      flag_q;
  logic                      flag_d;
  logic [sfs_pkg::TRK_W-1:0] cnt_q;
  logic [sfs_pkg::TRK_W-1:0] cnt_d;

  always_comb begin
    mag     = trk.err[sfs_pkg::ERR_W-1] ? (~trk.err + 24'h000001) : trk.err;
    outside = mag > trk.window;
    flag_d  = flag_q;
    cnt_d   = sfs_pkg::TRK_CNT_RST;
    if (outside) begin
      flag_d = 1'b1;
    end else if (flag_q) begin
      // clear only after a full continuous stay inside
      if (cnt_q >= trk.hold_time) begin
        flag_d = 1'b0;
      end else begin
        cnt_d = cnt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      flag_q <= 1'b0;
      cnt_q  <= sfs_pkg::TRK_CNT_RST;
    end else begin
      flag_q <= flag_d;
      cnt_q  <= cnt_d;
    end
  end

  assign trk.flag = flag_q;
endmodule : sfs_track
`default_nettype wire

// >>> core/sfs_track_if.sv
/*
  sfs_track_if: carries one tracking window check between modules.
  assumes a single clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
interface sfs_track_if;
  logic [sfs_pkg::ERR_W-1:0] err;
  logic [sfs_pkg::ERR_W-1:0] window;
  logic [sfs_pkg::TRK_W-1:0] hold_time;
  logic                      flag;
  modport owner (output err, output window, output hold_time, input flag);
  modport track (input err, input window, input hold_time, output flag);
endinterface : sfs_track_if
`default_nettype wire

// >>> testbench/servo_fault_supervisor_tb_top.sv
/*
  servo_fault_supervisor_tb_top: directed bench for sfs_supervisor.
  assumes the bound checker and the plant model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module servo_fault_supervisor_tb_top;
  logic core_clk = 1'b0;
  logic sys_rst  = 1'b1;
  logic short_ind, motor_thermal_pin, motor_thermal_hot_level, fb_supply_overcur, fb_signal_bad;
  logic phase_mismatch, brushless_sine, resolver_fb, hall_correct_en, cmd_signal_lost;
  logic brake_used, wiring_check_active, motor_current_seen, overcur_fault_en, heating_limit_hit;
  logic drive_current_reduced, latch_cfg_load, position_mode, follow_fault_en, pin_position_cmd;
  logic new_traj_cmd, enable_pin, enable_clears_faults, sw_enable, clear_cmd, motor_connected;
  logic [sfs_pkg::TEMP_W-1:0] amp_temp, amp_temp_limit;
  logic [sfs_pkg::VOLT_W-1:0] main_bus_supply, bus_upper_limit, bus_lower_limit;
  logic [sfs_pkg::VOLT_W-1:0] auxiliary_supply, supply_reset_level;
  logic [sfs_pkg::FLT_N-1:0]  latch_cfg, fault_flags;
  logic [sfs_pkg::ERR_W-1:0]  traj_position, actual_position, follow_fault_level;
  logic [sfs_pkg::ERR_W-1:0]  follow_warn_level, pos_window, vel_command, actual_velocity;
  logic [sfs_pkg::ERR_W-1:0]  vel_window;
  logic [sfs_pkg::TRK_W-1:0]  pos_track_time, vel_track_time;
  logic follow_warn, follow_status, pos_track_flag, vel_track_flag, stage_enable, brake_release;
  logic velocity_hold, fast_stop, fault_indicator, fault_out, log_valid;
  logic [sfs_pkg::FLT_W-1:0]  log_code;
  int                         miscompares = 0;
  int                         checks      = 0;

  always #4 core_clk = ~core_clk;
  sfs_supervisor i_dut (.*);
  sfs_plant i_plant (.*);

  task tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask : chk
  task conclude;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  task pulse_clear;
    clear_cmd <= 1'b1;
    tick(1);
    clear_cmd <= 1'b0;
    tick(3);
  endtask : pulse_clear
  // one fault condition on or off
  task set_cond(input int i, input logic v);
    case (i)
      0: short_ind <= v;
      1: amp_temp <= v ? 12'h200 : 12'h100;
      2: motor_thermal_pin <= v;
      3: main_bus_supply <= v ? 12'h400 : 12'h200;
      4: main_bus_supply <= v ? 12'h080 : 12'h200;
      5: fb_signal_bad <= v;
      6: phase_mismatch <= v;
      7: cmd_signal_lost <= v;
      8: begin
        wiring_check_active <= v;
        motor_connected     <= !v;
      end
      default: heating_limit_hit <= v;
    endcase
  endtask : set_cond
  // raise, refuse clear, drop, clear faults 0 to 9 in turn
  task fault_round(input logic [sfs_pkg::FLT_N-1:0] cfg);
    int d;
    for (int i = 0; i < 10; i++) begin
      d = (i == 2) ? 2 : (i == 8) ? 1 : 0;
      set_cond(i, 1'b1);
      tick(2 + d);
      chk(log_valid, 1);
      chk(log_code, i);
      tick(1);
      chk(fault_flags, 32'h1 << i);
      chk({stage_enable, fault_indicator, fault_out}, 3'b011);
      pulse_clear();
      chk(fault_flags[i], 1);
      set_cond(i, 1'b0);
      tick(4 + d);
      chk(fault_flags[i], cfg[i] | (i == 9));
      pulse_clear();
      chk({fault_flags, stage_enable}, 12'h001);
    end
  endtask : fault_round
  task load_cfg(input logic [sfs_pkg::FLT_N-1:0] cfg);
    latch_cfg      <= cfg;
    latch_cfg_load <= 1'b1;
    tick(1);
    latch_cfg_load <= 1'b0;
    tick(2);
  endtask : load_cfg

  initial begin
    {short_ind, motor_thermal_pin, fb_supply_overcur, fb_signal_bad, phase_mismatch} <= '0;
    {resolver_fb, cmd_signal_lost, wiring_check_active, heating_limit_hit} <= '0;
    {latch_cfg_load, pin_position_cmd, new_traj_cmd, enable_clears_faults, clear_cmd} <= '0;
    {motor_thermal_hot_level, brushless_sine, hall_correct_en, brake_used} <= '1;
    {overcur_fault_en, position_mode, follow_fault_en, enable_pin, sw_enable} <= '1;
    motor_connected <= 1'b1;
    {amp_temp, amp_temp_limit} <= {12'h100, 12'h180};
    {main_bus_supply, auxiliary_supply} <= {12'h200, 12'h200};
    {bus_upper_limit, bus_lower_limit, supply_reset_level} <= {12'h300, 12'h100, 12'h040};
    latch_cfg <= 11'h000;
    {traj_position, actual_position, vel_command, actual_velocity} <= '0;
    {follow_fault_level, follow_warn_level} <= {24'h000064, 24'h000032};
    {pos_window, vel_window} <= {24'h00000a, 24'h00000a};
    {pos_track_time, vel_track_time} <= {16'h0004, 16'h0004};
    tick(16);
    sys_rst <= 1'b0;
    tick(2);
    chk({fault_flags, stage_enable, log_code}, {11'h000, 1'b1, 4'hf});
    fault_round(sfs_pkg::LATCH_RST);
    load_cfg(11'h000);
    fault_round(11'h000);
    phase_mismatch <= 1'b1;
    resolver_fb    <= 1'b1;
    tick(3);
    chk(fault_flags[6], 0);
    resolver_fb     <= 1'b0;
    hall_correct_en <= 1'b0;
    tick(3);
    chk(fault_flags[6], 0);
    phase_mismatch  <= 1'b0;
    hall_correct_en <= 1'b1;
    traj_position   <= 24'h00003c;
    tick(3);
    chk({follow_warn, fault_flags[10], pos_track_flag}, 3'b101);
    traj_position <= 24'h000064;
    tick(3);
    chk({fast_stop, velocity_hold, stage_enable, follow_status}, 4'hf);
    traj_position <= '0;
    tick(3);
    new_traj_cmd <= 1'b1;
    tick(1);
    new_traj_cmd <= 1'b0;
    tick(3);
    chk(fault_flags[10], 0);
    pin_position_cmd <= 1'b1;
    traj_position    <= 24'hffff9c;
    tick(3);
    traj_position <= '0;
    new_traj_cmd  <= 1'b1;
    tick(1);
    new_traj_cmd <= 1'b0;
    tick(3);
    chk(fault_flags[10], 1);
    sw_enable <= 1'b0;
    tick(2);
    sw_enable <= 1'b1;
    tick(3);
    chk(fault_flags[10], 0);
    tick(8);
    traj_position <= 24'h000014;
    vel_command   <= 24'h000014;
    tick(1);
    traj_position <= '0;
    vel_command   <= '0;
    tick(5);
    chk({pos_track_flag, vel_track_flag, fault_flags}, 13'h1800);
    tick(1);
    chk({pos_track_flag, vel_track_flag}, 2'b00);
    follow_fault_en <= 1'b0;
    traj_position   <= 24'h0000c8;
    tick(3);
    chk({follow_warn, fault_flags[10]}, 2'b10);
    traj_position   <= '0;
    follow_fault_en <= 1'b1;
    load_cfg(sfs_pkg::LATCH_RST);
    pin_position_cmd <= 1'b0;
    traj_position    <= 24'h000064;
    tick(2);
    chk({log_valid, log_code}, 5'h1a);
    chk({stage_enable, brake_release, fast_stop, fault_out}, 4'h1);
    traj_position        <= '0;
    enable_clears_faults <= 1'b1;
    enable_pin           <= 1'b0;
    tick(4);
    enable_pin <= 1'b1;
    tick(5);
    chk(fault_flags[10], 0);
    enable_clears_faults <= 1'b0;
    short_ind            <= 1'b1;
    tick(2);
    short_ind       <= 1'b0;
    main_bus_supply <= 12'h020;
    tick(2);
    main_bus_supply <= 12'h200;
    tick(4);
    chk(fault_flags[0], 1);
    {main_bus_supply, auxiliary_supply} <= {12'h020, 12'h020};
    tick(2);
    {main_bus_supply, auxiliary_supply} <= {12'h200, 12'h200};
    tick(4);
    chk(fault_flags[0], 0);
    conclude();
  end
  initial begin
    tick(20000);
    miscompares++;
    conclude();
  end
endmodule : servo_fault_supervisor_tb_top
`default_nettype wire

// >>> testbench/sfs_plant.sv
/*
  sfs_plant: power stage and motor model facing the supervisor.
  assumes stage_enable comes from the supervisor on core_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module sfs_plant (
  input  wire logic core_clk,
  input  wire logic stage_enable,
  input  wire logic motor_connected,
  output logic      motor_current_seen,
  output logic      drive_current_reduced
);
  logic seen_q = 1'b0;
  logic low_q  = 1'b1;
  // current flows only into a connected motor with the stage on
  always_ff @(posedge core_clk) begin
    seen_q <= stage_enable && motor_connected;
    low_q  <= !stage_enable;
  end
  assign motor_current_seen    = seen_q;
  assign drive_current_reduced = low_q;
endmodule : sfs_plant
`default_nettype wire

// >>> testbench/sfs_supervisor_assertions.sv
/*
  sfs_supervisor_checker: port-level assertions for the fault supervisor.
  assumes it is bound to sfs_supervisor and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none
module sfs_supervisor_checker (
  input wire logic                       core_clk,
  input wire logic                       sys_rst,
  input wire logic                       short_ind,
  input wire logic [sfs_pkg::VOLT_W-1:0] main_bus_supply,
  input wire logic [sfs_pkg::VOLT_W-1:0] bus_upper_limit,
  input wire logic [sfs_pkg::VOLT_W-1:0] auxiliary_supply,
  input wire logic                       heating_limit_hit,
  input wire logic                       drive_current_reduced,
  input wire logic                       clear_cmd,
  input wire logic                       enable_clears_faults,
  input wire logic                       position_mode,
  input wire logic [sfs_pkg::ERR_W-1:0]  traj_position,
  input wire logic [sfs_pkg::ERR_W-1:0]  actual_position,
  input wire logic [sfs_pkg::ERR_W-1:0]  follow_warn_level,
  input wire logic [sfs_pkg::ERR_W-1:0]  pos_window,
  input wire logic [sfs_pkg::FLT_N-1:0]  fault_flags,
  input wire logic                       follow_warn,
  input wire logic                       pos_track_flag,
  input wire logic                       stage_enable,
  input wire logic                       brake_release,
  input wire logic                       velocity_hold,
  input wire logic                       fast_stop,
  input wire logic                       fault_indicator,
  input wire logic                       log_valid
);
  logic [sfs_pkg::ERR_W-1:0] pos_mag;
  // magnitude of the position error
  always_comb begin
    pos_mag = traj_position - actual_position;
    if (pos_mag[sfs_pkg::ERR_W-1]) begin
      pos_mag = -pos_mag;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  chk_reset_flags_clean: assert property (disable iff (1'b0) sys_rst |=>
    fault_flags == 11'h000 && stage_enable && !log_valid) else $error("flags not clean in reset");
  chk_short_raises: assert property (short_ind |=> fault_flags[0])
    else $error("short fault not raised");
  chk_over_volt_self: assert property (main_bus_supply <= bus_upper_limit |=>
    !fault_flags[3]) else $error("over voltage fault did not clear itself");
  chk_stage_cut_off: assert property ((|fault_flags[9:0]) |->
    !stage_enable && fault_indicator) else $error("stage on during fault");
  chk_hard_stop_brake: assert property (fault_flags[10] && !fast_stop |->
    !stage_enable && !brake_release) else $error("latched following fault left stage on");
  chk_soft_stop_hold: assert property (fast_stop && !(|fault_flags[9:0]) |->
    stage_enable && velocity_hold && fault_flags[10]) else $error("soft stop wrong");
  chk_warn_bit_set: assert property (position_mode && pos_mag >= follow_warn_level |=>
    follow_warn) else $error("warning bit not set");
  chk_pos_window_set: assert property (position_mode && pos_mag > pos_window |=>
    pos_track_flag) else $error("tracking bit not set");
  chk_oc_latch_hold: assert property (fault_flags[9] && !clear_cmd && !enable_clears_faults
    && $stable(main_bus_supply) && $stable(auxiliary_supply) |=> fault_flags[9])
    else $error("latched over current dropped without clear");
  chk_oc_clear_done: assert property (fault_flags[9] && clear_cmd && drive_current_reduced
    && !heating_limit_hit |=> !fault_flags[9]) else $error("over current not cleared");
  cover property (fast_stop);
  cover property ($fell(fault_flags[9]));
  cover property ($fell(pos_track_flag));
endmodule : sfs_supervisor_checker
bind sfs_supervisor sfs_supervisor_checker i_chk (.*);
`default_nettype wire
